// File: include/rtcc_cfg.svh
// offsets, field positions, reset values and timing counts of the counter registers
`ifndef RTCC_CFG_SVH
`define RTCC_CFG_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define RTCC_IDX_CTRL      8'h00
`define RTCC_IDX_STATUS    8'h0a
`define RTCC_IDX_DBG       8'h0b
`define RTCC_IDX_TRIM      8'h0c
`define RTCC_IDX_COUNT     8'h10

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define RTCC_CTRL_SWRST_BIT   0
`define RTCC_CTRL_ENABLE_BIT  1
`define RTCC_CTRL_MODE_LSB    2
`define RTCC_CTRL_TWELVE_BIT  6
`define RTCC_STATUS_SYNC_BIT  7
`define RTCC_DBG_RUN_BIT      0
`define RTCC_TRIM_SIGN_BIT    7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RTCC_DBG_RESET     8'h00
`define RTCC_TRIM_RESET    8'h00
`define RTCC_COUNT_RESET   32'h0000_0000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RTCC_CLK_PERIOD_NS   50
`define RTCC_TICK_PERIOD_NS  1000000
`define RTCC_TICK_CYCLES     (`RTCC_TICK_PERIOD_NS / `RTCC_CLK_PERIOD_NS)
`define RTCC_SYNC_CYCLES     3'h3

`endif

// File: include/rtcc_pkg.sv
// types shared by the counter register block
package rtcc_pkg;

  typedef enum logic [1:0] {
    COUNTER32_MODE,
    COUNTER16_MODE,
    CALENDAR_MODE,
    MODE_RESERVED
  } rtcc_mode_e;

  typedef enum logic [1:0] {
    PEND_NONE,
    PEND_COUNT,
    PEND_TRIM
  } rtcc_pend_e;

  typedef struct packed {
    logic [5:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtcc_cal_s;

  typedef struct packed {
    logic        enable;
    rtcc_mode_e  mode;
    logic        twelve_hour_select;
    logic        run_in_debug;
    logic [7:0]  rate_trim;
    logic [31:0] count;
    logic [15:0] presc;
    logic [6:0]  trim_win;
    rtcc_pend_e  pend_kind;
    logic [2:0]  pend_cnt;
    logic [31:0] pend_data;
    logic [31:0] rdata;
  } rtcc_state_s;

endpackage

// File: rtl/rtcc_cal_step.sv
// one-second advance of the packed calendar word
`timescale 1ns/1ps
module rtcc_cal_step
(
  input  rtcc_pkg::rtcc_cal_s cur_i,
  input  wire logic           twelve_i,
  output rtcc_pkg::rtcc_cal_s next_o
);
  import rtcc_pkg::*;

  function automatic logic [4:0] days_in_month(input logic [3:0] month, input logic leap);
    logic [4:0] d;
    d = 5'h1f;
    if (month == 4'h2)
    begin
      d = leap ? 5'h1d : 5'h1c;
    end
    else if (month == 4'h4 || month == 4'h6 || month == 4'h9 || month == 4'hb)
    begin
      d = 5'h1e;
    end
    return d;
  endfunction

  logic leap;
  logic day_roll;

  assign leap = (cur_i.year[1:0] == 2'h0);

  always_comb
  begin
    next_o   = cur_i;
    day_roll = 1'b0;
    next_o.second = cur_i.second + 6'h01;
    if (cur_i.second >= 6'h3b)
    begin
      next_o.second = 6'h00;
      next_o.minute = cur_i.minute + 6'h01;
      if (cur_i.minute >= 6'h3b)
      begin
        next_o.minute = 6'h00;
        if (!twelve_i)
        begin
          next_o.hour = cur_i.hour + 5'h01;
          if (cur_i.hour >= 5'h17)
          begin
            next_o.hour = 5'h00;
            day_roll    = 1'b1;
          end
        end
        else
        begin
          // 11 -> 12 flips the half-day; 11 PM -> 12 AM starts a new day
          next_o.hour[3:0] = cur_i.hour[3:0] + 4'h1;
          if (cur_i.hour[3:0] == 4'hb)
          begin
            next_o.hour[4] = ~cur_i.hour[4];
            day_roll       = cur_i.hour[4];
          end
          else if (cur_i.hour[3:0] >= 4'hc)
          begin
            next_o.hour[3:0] = 4'h1;
          end
        end
      end
    end
    if (day_roll)
    begin
      next_o.day = cur_i.day + 5'h01;
      if (cur_i.day >= days_in_month(cur_i.month, leap))
      begin
        next_o.day   = 5'h01;
        next_o.month = cur_i.month + 4'h1;
        if (cur_i.month >= 4'hc)
        begin
          next_o.month = 4'h1;
          next_o.year  = cur_i.year + 6'h01;
        end
      end
    end
  end

endmodule // rtcc_cal_step

// File: rtl/rtcc_regs.sv
// counter, 16-bit counter and calendar value registers with trim and debug halt
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "rtcc_cfg.svh"
module rtcc_regs
#(
  parameter int TICK_CYCLES = `RTCC_TICK_CYCLES
)
(
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic        DEBUG_HALT_I,
  output logic      [31:0] RDATA_O,
  output logic             SYNC_PENDING_O,
  output logic             TICK_O
);
  import rtcc_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
    return addr == byte_addr(idx);
  endfunction

  localparam logic [15:0] TICK_LIMIT = 16'(TICK_CYCLES - 1);

  rtcc_state_s st;
  rtcc_state_s next_st;
  rtcc_cal_s   cal_next;
  logic [31:0] count_step;
  logic [15:0] presc_limit;
  logic        running;
  logic        tick;
  logic        swrst;
  logic        pend_busy;

  rtcc_cal_step u_cal_step
  (
    .cur_i    (rtcc_cal_s'(st.count)),
    .twelve_i (st.twelve_hour_select),
    .next_o   (cal_next)
  );

  // ---------------------------------------------------------------
  // prescaler with trim
  // ---------------------------------------------------------------
  // correction is spread over a window of 128 ticks: the first |trim| ticks of each
  // window are one clock longer or shorter, so the average rate moves in proportion
  always_comb
  begin
    presc_limit = TICK_LIMIT;
    if (st.rate_trim[6:0] != 7'h00 && st.trim_win < st.rate_trim[6:0])
    begin
      if (st.rate_trim[`RTCC_TRIM_SIGN_BIT])
      begin
        presc_limit = TICK_LIMIT - 16'h0001;
      end
      else
      begin
        presc_limit = TICK_LIMIT + 16'h0001;
      end
    end
  end

  assign running = st.enable && !(DEBUG_HALT_I && !st.run_in_debug);
  assign tick    = running && (st.presc >= presc_limit);
  assign swrst   = WR_I && hit(ADDR_I, `RTCC_IDX_CTRL) && WDATA_I[`RTCC_CTRL_SWRST_BIT];
  assign pend_busy = (st.pend_kind != PEND_NONE);

  // ---------------------------------------------------------------
  // counter step by mode
  // ---------------------------------------------------------------
  always_comb
  begin
    count_step = st.count + 32'h0000_0001;
    if (st.mode == COUNTER16_MODE)
    begin
      count_step = {16'h0000, st.count[15:0] + 16'h0001};
    end
    else if (st.mode == CALENDAR_MODE)
    begin
      count_step = 32'(cal_next);
    end
    else if (st.mode == MODE_RESERVED)
    begin
      count_step = st.count;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.rdata = 32'h0000_0000;

    if (tick)
    begin
      next_st.presc    = 16'h0000;
      next_st.trim_win = st.trim_win + 7'h01;
      next_st.count    = count_step;
    end
    else if (running)
    begin
      next_st.presc = st.presc + 16'h0001;
    end

    // transfer into the counter domain completes after a fixed delay
    if (pend_busy)
    begin
      next_st.pend_cnt = st.pend_cnt - 3'h1;
      if (st.pend_cnt == 3'h1)
      begin
        next_st.pend_kind = PEND_NONE;
        if (st.pend_kind == PEND_COUNT)
        begin
          next_st.count = st.pend_data;
          next_st.presc = 16'h0000;
        end
        else
        begin
          next_st.rate_trim = st.pend_data[7:0];
        end
      end
    end

    if (WR_I)
    begin
      if (hit(ADDR_I, `RTCC_IDX_CTRL))
      begin
        next_st.enable             = WDATA_I[`RTCC_CTRL_ENABLE_BIT];
        next_st.mode               = rtcc_mode_e'(WDATA_I[`RTCC_CTRL_MODE_LSB +: 2]);
        next_st.twelve_hour_select = WDATA_I[`RTCC_CTRL_TWELVE_BIT];
      end
      else if (hit(ADDR_I, `RTCC_IDX_DBG))
      begin
        next_st.run_in_debug = WDATA_I[`RTCC_DBG_RUN_BIT];
      end
      else if (hit(ADDR_I, `RTCC_IDX_TRIM) && !pend_busy)
      begin
        next_st.pend_kind = PEND_TRIM;
        next_st.pend_cnt  = `RTCC_SYNC_CYCLES;
        next_st.pend_data = {24'h00_0000, WDATA_I[7:0]};
      end
      else if (hit(ADDR_I, `RTCC_IDX_COUNT) && !pend_busy)
      begin
        next_st.pend_kind = PEND_COUNT;
        next_st.pend_cnt  = `RTCC_SYNC_CYCLES;
        next_st.pend_data = WDATA_I;
        if (st.mode == COUNTER16_MODE)
        begin
          next_st.pend_data = {16'h0000, WDATA_I[15:0]};
        end
      end
    end

    if (RD_I)
    begin
      if (hit(ADDR_I, `RTCC_IDX_CTRL))
      begin
        next_st.rdata[`RTCC_CTRL_ENABLE_BIT]         = st.enable;
        next_st.rdata[`RTCC_CTRL_MODE_LSB +: 2]      = st.mode;
        next_st.rdata[`RTCC_CTRL_TWELVE_BIT]         = st.twelve_hour_select;
      end
      else if (hit(ADDR_I, `RTCC_IDX_STATUS))
      begin
        next_st.rdata[`RTCC_STATUS_SYNC_BIT] = pend_busy;
      end
      else if (hit(ADDR_I, `RTCC_IDX_DBG))
      begin
        next_st.rdata[`RTCC_DBG_RUN_BIT] = st.run_in_debug;
      end
      else if (hit(ADDR_I, `RTCC_IDX_TRIM))
      begin
        next_st.rdata[7:0] = st.rate_trim;
      end
      else if (hit(ADDR_I, `RTCC_IDX_COUNT))
      begin
        next_st.rdata = st.count;
        if (st.mode == COUNTER16_MODE)
        begin
          // a mode change can leave stale upper bits behind
          next_st.rdata = {16'h0000, st.count[15:0]};
        end
      end
    end

    // software reset clears everything but the debug run choice
    if (swrst)
    begin
      next_st.enable             = 1'b0;
      next_st.mode               = COUNTER32_MODE;
      next_st.twelve_hour_select = 1'b0;
      next_st.rate_trim          = `RTCC_TRIM_RESET;
      next_st.count              = `RTCC_COUNT_RESET;
      next_st.presc              = 16'h0000;
      next_st.trim_win           = 7'h00;
      next_st.pend_kind          = PEND_NONE;
      next_st.pend_cnt           = 3'h0;
      next_st.pend_data          = 32'h0000_0000;
      next_st.run_in_debug       = st.run_in_debug;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      st                    <= '0;
      st.mode               <= COUNTER32_MODE;
      st.pend_kind          <= PEND_NONE;
      st.run_in_debug       <= 1'(`RTCC_DBG_RESET);
      st.rate_trim          <= `RTCC_TRIM_RESET;
      st.count              <= `RTCC_COUNT_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign RDATA_O        = st.rdata;
  assign SYNC_PENDING_O = pend_busy;
  assign TICK_O         = tick;

endmodule // rtcc_regs

// File: testbench/rtcc_regs_assertions.sv
// concurrent checks on the ports of the counter register block
`timescale 1ns/1ps
module rtcc_regs_chk
#(
  parameter int TICK_CYCLES = 8
)
(
  input wire logic        MCLK_I,
  input wire logic        SYS_RST_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic        DEBUG_HALT_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        SYNC_PENDING_O,
  input wire logic        TICK_O
);
  logic run;
  logic wsync;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  // shadow of run-in-debug, untouched by a software reset
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      run <= 1'b0;
    end
    else if (WR_I && ADDR_I == 8'h2c)
    begin
      run <= WDATA_I[0];
    end
  end
  assign wsync = WR_I && !SYNC_PENDING_O && (ADDR_I == 8'h40 || ADDR_I == 8'h30);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sync_hold_a: assert property (wsync |=> SYNC_PENDING_O [*3] ##1 !SYNC_PENDING_O)
    else $error("sync pending length wrong");
  sync_cause_a: assert property ($rose(SYNC_PENDING_O) |-> $past(wsync))
    else $error("sync pending without write");
  rd_stat_a: assert property (RD_I && ADDR_I == 8'h28 |=>
    RDATA_O == {24'h0, $past(SYNC_PENDING_O), 7'h0}) else $error("status read wrong");
  halt_tick_a: assert property (DEBUG_HALT_I && !run |-> !TICK_O)
    else $error("step while halted");
  tick_gap_a: assert property (TICK_O |=> !TICK_O [*2])
    else $error("steps too close");
  rd_dbg_a: assert property (RD_I && ADDR_I == 8'h2c |=>
    RDATA_O == {31'h0, $past(run)}) else $error("debug control read wrong");
  rd_idle_a: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data outside read");
  rd_free_a: assert property (RD_I && ADDR_I == 8'h04 |=> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  cover property (wsync);
  cover property (TICK_O && DEBUG_HALT_I);
  cover property (WR_I && ADDR_I == 8'h40 && SYNC_PENDING_O);
  cover property (RD_I && ADDR_I == 8'h40);
endmodule // rtcc_regs_chk

bind rtcc_regs rtcc_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .DEBUG_HALT_I(DEBUG_HALT_I), .RDATA_O(RDATA_O),
  .SYNC_PENDING_O(SYNC_PENDING_O), .TICK_O(TICK_O)
);

// File: testbench/test_rtcc_regs.sv
// self-checking bench for the counter register block
`timescale 1ns/1ps
module test_rtcc_regs;
  import rtcc_pkg::*;
  logic        MCLK_I = 1'b0;
  logic        SYS_RST_I = 1'b1;
  logic [7:0]  ADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0;
  logic        WR_I = 1'b0;
  logic        RD_I = 1'b0;
  logic        DEBUG_HALT_I = 1'b0;
  logic [31:0] RDATA_O;
  logic        SYNC_PENDING_O;
  logic        TICK_O;
  int          err_count = 0;
  int          samples_checked = 0;

  rtcc_regs #(.TICK_CYCLES(8)) dut (
    .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .DEBUG_HALT_I(DEBUG_HALT_I), .RDATA_O(RDATA_O),
    .SYNC_PENDING_O(SYNC_PENDING_O), .TICK_O(TICK_O)
  );

  initial
  begin
    forever #25 MCLK_I = ~MCLK_I;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK_I);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK_I);
    WR_I <= 1'b1;
    ADDR_I <= a;
    WDATA_I <= d;
    @(posedge MCLK_I);
    WR_I <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge MCLK_I);
    RD_I <= 1'b1;
    ADDR_I <= a;
    @(posedge MCLK_I);
    RD_I <= 1'b0;
    #1 chk(RDATA_O, exp);
  endtask

  // cycles from the current step to the next one, bounded
  task automatic tick_gap(output int n);
    n = 0;
    do
    begin
      @(posedge MCLK_I);
      #1 n++;
      if (n > 60)
      begin
        err_count++;
        conclude();
      end
    end
    while (TICK_O !== 1'b1);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(8'h2c, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h28, 32'h0);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, 32'h0);
  endtask

  // second write lands while the first is still crossing: dropped
  task automatic t_sync;
    wr(8'h40, 32'hdead_beef);
    #1 chk(32'(SYNC_PENDING_O), 32'h1);
    wr(8'h40, 32'h1);
    rd(8'h40, 32'hdead_beef);
    chk(32'(SYNC_PENDING_O), 32'h0);
    wr(8'h40, 32'h5);
    rd(8'h28, 32'h80);
    cyc(2);
    rd(8'h28, 32'h0);
    chk(32'(SYNC_PENDING_O), 32'h0);
  endtask

  // upper half hidden in 16-bit mode, wrap at the top, mode 3 holds still
  task automatic t_mode16;
    int n;
    wr(8'h40, 32'h1234_5678);
    cyc(2);
    wr(8'h00, 32'h4);
    rd(8'h40, 32'h5678);
    wr(8'h40, 32'habcd_ffff);
    cyc(2);
    rd(8'h40, 32'hffff);
    wr(8'h00, 32'h6);
    tick_gap(n);
    rd(8'h40, 32'h0);
    wr(8'h00, 32'he);
    cyc(20);
    rd(8'h40, 32'h0);
  endtask

  task automatic t_debug;
    int n;
    wr(8'h00, 32'h1);
    wr(8'h2c, 32'h0);
    DEBUG_HALT_I <= 1'b1;
    wr(8'h40, 32'h100);
    cyc(2);
    wr(8'h00, 32'h2);
    cyc(40);
    rd(8'h40, 32'h100);
    wr(8'h2c, 32'h1);
    tick_gap(n);
    tick_gap(n);
    chk(n, 8);
    rd(8'h40, 32'h102);
    wr(8'h00, 32'h1);
    rd(8'h2c, 32'h1);
    rd(8'h40, 32'h0);
    wr(8'h2c, 32'h0);
  endtask

  task automatic t_trim(input logic [31:0] v, input int g);
    int n;
    DEBUG_HALT_I <= 1'b0;
    wr(8'h00, 32'h1);
    wr(8'h30, v);
    cyc(2);
    wr(8'h00, 32'h2);
    tick_gap(n);
    tick_gap(n);
    chk(n, g);
    rd(8'h30, v);
  endtask

  // one step let through by a short release of the debug halt
  task automatic t_cal(input logic [31:0] s, input logic [31:0] c, input logic [31:0] e);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h8);
    wr(8'h40, s);
    cyc(2);
    DEBUG_HALT_I <= 1'b1;
    wr(8'h00, c);
    @(posedge MCLK_I);
    DEBUG_HALT_I <= 1'b0;
    cyc(12);
    DEBUG_HALT_I <= 1'b1;
    rd(8'h40, e);
  endtask

  // every start value below keeps the hour field in its legal range
  initial
  begin
    cyc(10);
    SYS_RST_I <= 1'b0;
    t_reset();
    t_sync();
    t_mode16();
    t_debug();
    t_trim(32'h00, 8);
    t_trim(32'h02, 9);
    t_trim(32'h82, 7);
    t_cal(rtcc_cal_s'{6'h01, 4'h2, 5'h1c, 5'h17, 6'h3b, 6'h3b}, 32'h0a,
          rtcc_cal_s'{6'h01, 4'h3, 5'h01, 5'h00, 6'h00, 6'h00});
    t_cal(rtcc_cal_s'{6'h04, 4'h2, 5'h1c, 5'h17, 6'h3b, 6'h3b}, 32'h0a,
          rtcc_cal_s'{6'h04, 4'h2, 5'h1d, 5'h00, 6'h00, 6'h00});
    t_cal(rtcc_cal_s'{6'h00, 4'hc, 5'h1f, 5'h17, 6'h3b, 6'h3b}, 32'h0a,
          rtcc_cal_s'{6'h01, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00});
    t_cal(rtcc_cal_s'{6'h00, 4'h1, 5'h01, 5'h0b, 6'h3b, 6'h3b}, 32'h4a,
          rtcc_cal_s'{6'h00, 4'h1, 5'h01, 5'h1c, 6'h00, 6'h00});
    t_cal(rtcc_cal_s'{6'h00, 4'h1, 5'h01, 5'h1c, 6'h3b, 6'h3b}, 32'h4a,
          rtcc_cal_s'{6'h00, 4'h1, 5'h01, 5'h11, 6'h00, 6'h00});
    t_cal(rtcc_cal_s'{6'h00, 4'h1, 5'h01, 5'h1b, 6'h3b, 6'h3b}, 32'h4a,
          rtcc_cal_s'{6'h00, 4'h1, 5'h02, 5'h0c, 6'h00, 6'h00});
    conclude();
  end
endmodule // test_rtcc_regs
